// File: logic/cgs_consts.vh
/*
  register offsets, field positions, reset values and timing counts for the
  clock generator status, filter and trim block.
  assumes: included by the design file by its bare name.
*/
`ifndef CGS_CONSTS_VH
`define CGS_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CGS_OFF_STATUS_MAIN  8'h00
`define CGS_OFF_STATUS_OSC   8'h04
`define CGS_OFF_FILTER_UPPER 8'h08
`define CGS_OFF_FILTER_LOWER 8'h0c
`define CGS_OFF_TRIM         8'h10
`define CGS_OFF_CONTROL      8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CGS_MODE_HI          7
`define CGS_MODE_LO          6
`define CGS_REFSRC_BIT       5
`define CGS_LOL_BIT          4
`define CGS_LOCK_BIT         3
`define CGS_LOC_BIT          2
`define CGS_ERV_BIT          1
`define CGS_IRQ_BIT          0
`define CGS_STABLE_BIT       0
`define CGS_CTL_LOCK_LOSS_RESET_ENABLE_BIT    7
`define CGS_CTL_CLOCK_LOSS_RESET_ENABLE_BIT    3

// ----------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------
`define CGS_MODE_SELF        2'h0
`define CGS_MODE_ENG_INT     2'h1
`define CGS_MODE_BYP_EXT     2'h2
`define CGS_MODE_ENG_EXT     2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CGS_FILTER_RESET     12'h000
`define CGS_TRIM_RESET       8'h80
`define CGS_CTL_RESET        8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CGS_LATCH_CYCLES     2'h2

`endif

// File: logic/cgs_status_filter_trim.v
/*
  status, filter and trim registers of the clock generator, as an
  ahb-lite slave with zero wait states.
  assumes: the mode machine, lock detector, clock monitors and oscillator
  sit outside and report through level inputs on hclk; they read back the
  filter value, trim and the interrupt and reset requests from the outputs here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cgs_consts.vh"

module cgs_status_filter_trim #(
  parameter FILTER_WIDTH = 12
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // mode machine interface
  input  wire [1:0]  clock_mode_select,
  input  wire [1:0]  active_mode,
  input  wire        gen_off,
  input  wire        reference_crystal,
  // monitors
  input  wire        fll_locked,
  input  wire        lock_lost_event,
  input  wire        clock_lost_event,
  input  wire        ext_reference_stable,
  input  wire        count_error_settled,
  input  wire        osc_core_clock_active,
  input  wire        loop_filter_update,
  input  wire [11:0] loop_filter_value,
  // outputs to the clock generator
  output reg  [11:0] filter_value_ff,
  output reg  [7:0]  trim_ff,
  output wire        clkgen_irq_req,
  output wire        clkgen_reset_req,
  output wire        osc_monitor_enable,
  output wire        engage_allowed
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [1:0]  mode_sync1_ff;
  reg  [1:0]  clock_mode_status_ff;
  reg         loss_of_lock_flag_ff;
  reg         clock_loss_flag_ff;
  reg         clkgen_irq_flag_ff;
  reg         clear_armed_ff;
  reg         osc_core_stable_ff;
  reg  [7:0]  control_ff;
  reg  [1:0]  latch_cnt_ff;
  reg  [3:0]  upper_hold_ff;
  reg  [7:0]  lower_hold_ff;
  reg         dp_valid_ff;
  reg         dp_write_ff;
  reg  [7:0]  dp_addr_ff;
  reg  [31:0] hrdata_ff;

  wire        lock_loss_reset_enable;
  wire        clock_loss_reset_enable;
  wire        addr_take;
  wire        wr_go;
  wire        rd_go;
  wire        lol_irq;
  wire        loc_irq;
  wire        irq_event;
  wire        irq_clear;
  wire        filter_writable;
  wire        latch_busy;
  wire        lock_bit;
  wire [7:0]  status_main;
  reg  [31:0] nxt_hrdata;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // address phase captured when the bus is ready; always ok, zero wait
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_go     = dp_valid_ff & dp_write_ff;
  assign rd_go     = addr_take & ~hwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a[7:2] == off[7:2]);
    end
  endfunction

  // data phase registers: target, direction and validity for the next cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff  <= 8'h00;
    end else begin
      dp_valid_ff <= addr_take;
      dp_write_ff <= hwrite;
      dp_addr_ff  <= haddr;
    end
  end

  // ----------------------------------------------------------------------
  // status composition
  // ----------------------------------------------------------------------
  // lock bit masked outside the engaged modes
  assign lock_bit = fll_locked & ~gen_off &
                    (clock_mode_status_ff == `CGS_MODE_ENG_INT |
                     clock_mode_status_ff == `CGS_MODE_ENG_EXT);

  assign status_main = {clock_mode_status_ff,
                        reference_crystal,
                        loss_of_lock_flag_ff,
                        lock_bit,
                        clock_loss_flag_ff,
                        ext_reference_stable,
                        clkgen_irq_flag_ff};

  // read mux, data stands from the address phase edge
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (hit(haddr, `CGS_OFF_STATUS_MAIN))
      nxt_hrdata[7:0] = status_main;
    else if (hit(haddr, `CGS_OFF_STATUS_OSC))
      nxt_hrdata[`CGS_STABLE_BIT] = osc_core_stable_ff;
    else if (hit(haddr, `CGS_OFF_FILTER_UPPER))
      nxt_hrdata[3:0] = filter_value_ff[11:8];
    else if (hit(haddr, `CGS_OFF_FILTER_LOWER))
      nxt_hrdata[7:0] = filter_value_ff[7:0];
    else if (hit(haddr, `CGS_OFF_TRIM))
      nxt_hrdata[7:0] = trim_ff;
    else if (hit(haddr, `CGS_OFF_CONTROL))
      nxt_hrdata[7:0] = control_ff;
  end

  // read data captured at the address phase, held until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata_ff <= 32'h00000000;
    else if (rd_go)
      hrdata_ff <= nxt_hrdata;
  end

  // ----------------------------------------------------------------------
  // mode status synchroniser
  // ----------------------------------------------------------------------
  // two stages, so an active_mode change reaches the status bits two cycles later
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_sync1_ff        <= `CGS_MODE_SELF;
      clock_mode_status_ff <= `CGS_MODE_SELF;
    end else begin
      mode_sync1_ff        <= active_mode;
      clock_mode_status_ff <= mode_sync1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // reset-enable control register
  // ----------------------------------------------------------------------
  assign lock_loss_reset_enable  = control_ff[`CGS_CTL_LOCK_LOSS_RESET_ENABLE_BIT];
  assign clock_loss_reset_enable = control_ff[`CGS_CTL_CLOCK_LOSS_RESET_ENABLE_BIT];

  // reset enables and scratch bits, written in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      control_ff <= `CGS_CTL_RESET;
    else if (wr_go && hit(dp_addr_ff, `CGS_OFF_CONTROL))
      control_ff <= hwdata[7:0];
  end

  // ----------------------------------------------------------------------
  // sticky loss flags
  // ----------------------------------------------------------------------
  // flags hold until the irq clear sequence completes; set wins over clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loss_of_lock_flag_ff <= 1'b0;
      clock_loss_flag_ff   <= 1'b0;
    end else begin
      if (lock_lost_event)
        loss_of_lock_flag_ff <= 1'b1;
      else if (irq_clear)
        loss_of_lock_flag_ff <= 1'b0;
      if (clock_lost_event)
        clock_loss_flag_ff <= 1'b1;
      else if (irq_clear)
        clock_loss_flag_ff <= 1'b0;
    end
  end

  // requests routed by the reset enables
  assign lol_irq = lock_lost_event & ~lock_loss_reset_enable;
  assign loc_irq = clock_lost_event & ~clock_loss_reset_enable;
  assign clkgen_reset_req = (loss_of_lock_flag_ff & lock_loss_reset_enable) |
                            (clock_loss_flag_ff & clock_loss_reset_enable);
  assign irq_event = lol_irq | loc_irq;

  // ----------------------------------------------------------------------
  // interrupt flag and clear sequence
  // ----------------------------------------------------------------------
  // clear needs a status read with flag set, then a write of one
  assign irq_clear = wr_go & hit(dp_addr_ff, `CGS_OFF_STATUS_MAIN) &
                     hwdata[`CGS_IRQ_BIT] & clear_armed_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clkgen_irq_flag_ff <= 1'b0;
      clear_armed_ff     <= 1'b0;
    end else begin
      if (irq_event) begin
        clkgen_irq_flag_ff <= 1'b1;
        clear_armed_ff     <= 1'b0;
      end else begin
        if (irq_clear) begin
          clkgen_irq_flag_ff <= 1'b0;
          clear_armed_ff     <= 1'b0;
        end else if (rd_go && hit(haddr, `CGS_OFF_STATUS_MAIN) && clkgen_irq_flag_ff)
          clear_armed_ff <= 1'b1;
      end
    end
  end
  assign clkgen_irq_req = clkgen_irq_flag_ff;

  // ----------------------------------------------------------------------
  // oscillator stable bit
  // ----------------------------------------------------------------------
  // registered stable flag, dropped whenever the generator is off
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      osc_core_stable_ff <= 1'b0;
    else if (gen_off)
      osc_core_stable_ff <= 1'b0;
    else
      osc_core_stable_ff <= count_error_settled & osc_core_clock_active;
  end

  // engaged modes wait on stability; monitor only once stable
  assign engage_allowed     = osc_core_stable_ff & ~gen_off;
  assign osc_monitor_enable = osc_core_stable_ff &
                              (clock_mode_status_ff != `CGS_MODE_SELF |
                               ~gen_off);

  // ----------------------------------------------------------------------
  // filter value
  // ----------------------------------------------------------------------
  assign filter_writable = (clock_mode_select == `CGS_MODE_SELF);
  assign latch_busy      = (latch_cnt_ff != 2'h0);

  // lower write is held; upper write commits all twelve bits together
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_value_ff <= `CGS_FILTER_RESET;
      latch_cnt_ff    <= 2'h0;
      upper_hold_ff   <= 4'h0;
      lower_hold_ff   <= 8'h00;
    end else begin
      if (latch_cnt_ff == 2'h1)
        filter_value_ff <= {upper_hold_ff, lower_hold_ff};
      else if (!filter_writable && loop_filter_update)
        filter_value_ff <= loop_filter_value;
      if (latch_busy)
        latch_cnt_ff <= latch_cnt_ff - 2'h1;
      if (wr_go && filter_writable && hit(dp_addr_ff, `CGS_OFF_FILTER_LOWER))
        lower_hold_ff <= hwdata[7:0];
      if (wr_go && filter_writable && !latch_busy &&
          hit(dp_addr_ff, `CGS_OFF_FILTER_UPPER)) begin
        upper_hold_ff <= hwdata[3:0];
        latch_cnt_ff  <= `CGS_LATCH_CYCLES;
      end
    end
  end

  // ----------------------------------------------------------------------
  // trim
  // ----------------------------------------------------------------------
  // binary weighted code straight to the reference period control
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      trim_ff <= `CGS_TRIM_RESET;
    else if (wr_go && hit(dp_addr_ff, `CGS_OFF_TRIM))
      trim_ff <= hwdata[7:0];
  end

endmodule // cgs_status_filter_trim
`default_nettype wire

// File: testbench/cgs_status_filter_trim_asserts.sv
/*
  checker for the clock generator status, filter and trim block.
  assumes: bound to the design top; one clock domain, async low reset.
*/
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module cgs_status_filter_trim_asserts (
  // clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  // monitors and mode
  input wire logic [1:0]  clock_mode_select,
  input wire logic        gen_off,
  input wire logic        count_error_settled,
  input wire logic        osc_core_clock_active,
  input wire logic        lock_lost_event,
  input wire logic        clock_lost_event,
  input wire logic        loop_filter_update,
  // outputs watched
  input wire logic [11:0] filter_value_ff,
  input wire logic [7:0]  trim_ff,
  input wire logic        clkgen_irq_req,
  input wire logic        clkgen_reset_req,
  input wire logic        osc_monitor_enable,
  input wire logic        engage_allowed
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus write request and non-self-clocked select
  wire wr_req = hsel && htrans[1] && hwrite && hready;
  wire sel_nz = clock_mode_select != 2'h0;

  property p_stable_off; gen_off |=> !engage_allowed; endproperty
  a_stable_off: assert property (p_stable_off) else $error("stable kept in off");
  property p_stable_set;
    (hresetn && !gen_off && count_error_settled && osc_core_clock_active) ##1 !gen_off
      |-> engage_allowed;
  endproperty
  a_stable_set: assert property (p_stable_set) else $error("stable not set");
  property p_engage_src;
    $rose(engage_allowed) |-> $past(count_error_settled && osc_core_clock_active);
  endproperty
  a_engage_src: assert property (p_engage_src) else $error("engage without stable");
  property p_mon_gate; !engage_allowed |-> !osc_monitor_enable; endproperty
  a_mon_gate: assert property (p_mon_gate) else $error("monitor before stable");
  property p_filter_ro;
    (sel_nz && $past(sel_nz) && $past(sel_nz, 2) && $past(sel_nz, 3)
      && !$past(loop_filter_update)) |-> $stable(filter_value_ff);
  endproperty
  a_filter_ro: assert property (p_filter_ro) else $error("filter written");
  property p_lol_act; lock_lost_event |=> clkgen_irq_req || clkgen_reset_req; endproperty
  a_lol_act: assert property (p_lol_act) else $error("lock loss no request");
  property p_loc_act; clock_lost_event |=> clkgen_irq_req || clkgen_reset_req; endproperty
  a_loc_act: assert property (p_loc_act) else $error("clock loss no request");
  property p_irq_hold;
    $fell(clkgen_irq_req) |-> $past(wr_req) || $past(wr_req, 2);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");
  property p_trim_wr; $changed(trim_ff) |-> $past(wr_req) || $past(wr_req, 2); endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim changed alone");

  c_irq: cover property ($rose(clkgen_irq_req));
  c_filt: cover property ($changed(filter_value_ff));
  c_rst: cover property ($rose(clkgen_reset_req));
endmodule // cgs_status_filter_trim_asserts

bind cgs_status_filter_trim cgs_status_filter_trim_asserts u_chk (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hready, .clock_mode_select, .gen_off, .count_error_settled,
  .osc_core_clock_active, .lock_lost_event, .clock_lost_event, .loop_filter_update,
  .filter_value_ff, .trim_ff, .clkgen_irq_req, .clkgen_reset_req, .osc_monitor_enable,
  .engage_allowed);
`default_nettype wire

// File: testbench/cgs_status_filter_trim_tb.sv
/*
  self-checking bench for the clock generator status, filter and trim block.
  assumes: zero-wait ahb-lite slave; checker bound from its own file.
*/
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module cgs_status_filter_trim_tb;
  logic        hclk, hresetn, hsel, hwrite, gen_off, reference_crystal, fll_locked;
  logic        lock_lost_event, clock_lost_event, ext_reference_stable;
  logic        count_error_settled, osc_core_clock_active, loop_filter_update;
  logic [7:0]  haddr;
  logic [1:0]  htrans, clock_mode_select, active_mode;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd;
  logic [11:0] loop_filter_value;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, clkgen_irq_req, clkgen_reset_req;
  wire         osc_monitor_enable, engage_allowed;
  wire  [11:0] filter_value_ff;
  wire  [7:0]  trim_ff;
  int          mismatches, compares;

  cgs_status_filter_trim dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .clock_mode_select,
    .active_mode, .gen_off, .reference_crystal, .fll_locked, .lock_lost_event,
    .clock_lost_event, .ext_reference_stable, .count_error_settled, .osc_core_clock_active,
    .loop_filter_update, .loop_filter_value, .filter_value_ff, .trim_ff, .clkgen_irq_req,
    .clkgen_reset_req, .osc_monitor_enable, .engage_allowed);

  // 25 mhz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single word transfer, read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    cyc(20);
    hresetn <= 1'b1;
  endtask

  // one-cycle loss event, clock loss when c is set
  task automatic pulse(input logic c);
    @(posedge hclk);
    if (c) clock_lost_event <= 1'b1;
    else lock_lost_event <= 1'b1;
    @(posedge hclk);
    clock_lost_event <= 1'b0;
    lock_lost_event <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // trim reset value, read-write, unmapped read
  task automatic t_regs;
    xfer(1'b0, 8'h10, 32'h0);
    chk("trim reset", rd, 32'h80);
    xfer(1'b1, 8'h10, 32'h3c);
    xfer(1'b0, 8'h10, 32'h0);
    chk("trim read", rd, 32'h3c);
    chk("trim out", {24'h0, trim_ff}, 32'h3c);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask

  // every mode code with its reference and lock bits
  task automatic t_status;
    logic [1:0] mb;
    for (int m = 0; m < 4; m++) begin
      mb = m[1:0];
      @(posedge hclk);
      active_mode <= mb;
      reference_crystal <= mb[0];
      ext_reference_stable <= mb[1];
      cyc(4);
      xfer(1'b0, 8'h00, 32'h0);
      chk("status", rd, {24'h0, mb, mb[0], 1'b0, mb[0], 1'b0, mb[1], 1'b0});
    end
    active_mode <= 2'h0;
    xfer(1'b0, 8'h00, 32'h0);
    chk("mode lag", {30'h0, rd[7:6]}, 32'h3);
    xfer(1'b0, 8'h00, 32'h0);
    chk("mode new", {30'h0, rd[7:6]}, 32'h0);
  endtask

  // stable bit sets, gates engage and monitoring, clears in off
  task automatic t_stable;
    @(posedge hclk);
    count_error_settled <= 1'b1;
    osc_core_clock_active <= 1'b1;
    cyc(3);
    xfer(1'b0, 8'h04, 32'h0);
    chk("stable", rd, 32'h1);
    chk("engage", {31'h0, engage_allowed}, 32'h1);
    gen_off <= 1'b1;
    cyc(3);
    xfer(1'b0, 8'h04, 32'h0);
    chk("stable off", rd, 32'h0);
    chk("monitor", {31'h0, osc_monitor_enable}, 32'h0);
    gen_off <= 1'b0;
  endtask

  // filter load, readback, lock-out outside self-clocked
  task automatic t_filter;
    xfer(1'b1, 8'h0c, 32'h5a);
    xfer(1'b1, 8'h08, 32'h03);
    cyc(3);
    chk("filter", {20'h0, filter_value_ff}, 32'h35a);
    xfer(1'b0, 8'h08, 32'h0);
    chk("flt upper", rd, 32'h3);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("flt lower", rd, 32'h5a);
    clock_mode_select <= 2'h1;
    cyc(4);
    xfer(1'b1, 8'h08, 32'h0f);
    cyc(3);
    chk("filter ro", {20'h0, filter_value_ff}, 32'h35a);
    loop_filter_value <= 12'habc;
    loop_filter_update <= 1'b1;
    @(posedge hclk);
    loop_filter_update <= 1'b0;
    cyc(2);
    chk("loop filter", {20'h0, filter_value_ff}, 32'habc);
    clock_mode_select <= 2'h0;
  endtask

  // back-to-back upper writes: the second lands while the latch is busy
  task automatic t_latch;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= 8'h08;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hwdata <= 32'h07;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= 32'h0e;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    cyc(3);
    chk("latch busy", {20'h0, filter_value_ff}, 32'h75a);
  endtask

  // irq set, clear sequence, restart, reset requests
  task automatic t_irq;
    xfer(1'b1, 8'h14, 32'h0);
    pulse(1'b0);
    cyc(2);
    chk("irq", {31'h0, clkgen_irq_req}, 32'h1);
    xfer(1'b0, 8'h00, 32'h0);
    chk("lol flag", rd & 32'h11, 32'h11);
    xfer(1'b1, 8'h00, 32'h0);
    cyc(1);
    chk("irq w0", {31'h0, clkgen_irq_req}, 32'h1);
    xfer(1'b0, 8'h00, 32'h0);
    pulse(1'b1);
    xfer(1'b1, 8'h00, 32'h1);
    cyc(1);
    chk("irq restart", {31'h0, clkgen_irq_req}, 32'h1);
    xfer(1'b0, 8'h00, 32'h0);
    chk("loc flag", rd & 32'h05, 32'h05);
    xfer(1'b1, 8'h00, 32'h1);
    cyc(1);
    chk("irq clear", {31'h0, clkgen_irq_req}, 32'h0);
    do_reset();
    xfer(1'b1, 8'h14, 32'h80);
    pulse(1'b0);
    cyc(2);
    chk("lol reset", {31'h0, clkgen_reset_req}, 32'h1);
    do_reset();
    xfer(1'b1, 8'h14, 32'h08);
    pulse(1'b1);
    cyc(2);
    chk("loc reset", {31'h0, clkgen_reset_req}, 32'h1);
    do_reset();
  endtask

  // main sequence
  initial begin
    {hsel, hwrite, gen_off, reference_crystal, lock_lost_event, clock_lost_event} = '0;
    {ext_reference_stable, count_error_settled, osc_core_clock_active} = '0;
    {haddr, htrans, clock_mode_select, active_mode, hwdata} = '0;
    loop_filter_update = 1'b0;
    loop_filter_value = 12'h0;
    hsize = 3'h2;
    fll_locked = 1'b1;
    mismatches = 0;
    compares = 0;
    do_reset();
    t_regs();
    t_status();
    t_stable();
    t_filter();
    t_latch();
    t_irq();
    give_verdict();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    give_verdict();
  end
endmodule // cgs_status_filter_trim_tb
`default_nettype wire
